//--- pkg/flash_map.svh
// opcodes, status bit layout, reset values and self-timed cycle figures
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// single-byte instruction codes
`define OP_WRITE_ENABLE       8'h06
`define OP_WRITE_DISABLE      8'h04
`define OP_VOL_WRITE_ENABLE   8'h50
`define OP_STATUS_WRITE_ALL   8'h01
`define OP_STATUS_WRITE_TWO   8'h31
`define OP_STATUS_WRITE_THREE 8'h11
`define OP_STATUS_READ_ONE    8'h05
`define OP_STATUS_READ_TWO    8'h35
`define OP_STATUS_READ_THREE  8'h15
`define OP_PAGE_PROGRAM       8'h02
`define OP_QUAD_PAGE_PROGRAM  8'h32
`define OP_SECTOR_ERASE       8'h20
`define OP_HALF_BLOCK_ERASE   8'h52
`define OP_BLOCK_ERASE        8'hD8

// status bit positions
`define SR1_BUSY_BIT 0
`define SR1_WEL_BIT  1
`define SR1_BP_LSB   2
`define SR1_TB_BIT   5
`define SR1_SEC_BIT  6
`define SR2_QE_BIT   1
`define SR2_CMP_BIT  6

// writable fields, one-time lock bits, bits kept by a volatile write
`define SR1_WRITE_MASK    8'hFC
`define SR2_WRITE_MASK    8'h7F
`define SR3_WRITE_MASK    8'hF0
`define SR2_LOCK_MASK     8'h38
`define SR2_VOL_KEEP_MASK 8'h39
`define SR2_SHORT_MASK    8'h43

// reset values of the stored status bytes
`define SR1_RESET 8'h00
`define SR2_RESET 8'h00
`define SR3_RESET 8'h00

// array geometry in bytes
`define SECTOR_BYTES     23'h001000
`define HALF_BLOCK_BYTES 23'h008000
`define BLOCK_BYTES      23'h010000
`define ARRAY_BYTES      23'h200000

// self-timed cycle figures
`define CORE_CLK_MHZ          50
`define STATUS_WRITE_TIME_US  15000
`define PAGE_PROGRAM_TIME_US  3000
`define SECTOR_ERASE_TIME_US  400000
`define BLOCK_ERASE_TIME_US   1600000

`endif

//--- pkg/flash_pkg.sv
// shared types of the program and erase sequencer
package flash_pkg;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_STREAM = 2'b01,
    ST_TIMED  = 2'b10
  } core_state_t;

  typedef enum logic [1:0] {
    ERASE_4K  = 2'b00,
    ERASE_32K = 2'b01,
    ERASE_64K = 2'b10
  } erase_size_t;

  // one request to the array: a byte write or an erase of a region
  typedef struct packed {
    logic        we;
    logic        erase;
    erase_size_t size;
    logic [23:0] addr;
    logic [7:0]  data;
  } mem_cmd_t;

  // what the link side has gathered in the current or last frame
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [9:0]  nbytes;
    logic [2:0]  bitpos;
    logic        quad;
  } frame_t;

  typedef struct packed {
    logic [7:0] one;
    logic [7:0] two;
    logic [7:0] three;
  } status_t;

endpackage

//--- src/flash_write_program_erase.sv
// write, program and erase sequencer of a serial nor flash
`timescale 1ns/1ps
`include "flash_map.svh"

module flash_write_program_erase
  import flash_pkg::*;
#(
  parameter int unsigned STATUS_WRITE_CYCLES = `STATUS_WRITE_TIME_US * `CORE_CLK_MHZ,
  parameter int unsigned PAGE_PROGRAM_CYCLES = `PAGE_PROGRAM_TIME_US * `CORE_CLK_MHZ,
  parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_TIME_US * `CORE_CLK_MHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES  = `BLOCK_ERASE_TIME_US * `CORE_CLK_MHZ
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       serial_clk,
  input  wire logic       chip_sel_n,
  input  wire logic [3:0] io_in,
  output logic [3:0]      io_out,
  output logic [3:0]      io_oe,
  output mem_cmd_t        mem_cmd,
  output status_t         status_view
);

  // masked replacement of a status byte
  function automatic logic [7:0] apply_bits(input logic [7:0] old_v,
                                            input logic [7:0] new_v,
                                            input logic [7:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // true when an address lies in the region fenced off by the protect bits
  function automatic logic is_protected(input logic [23:0] a, input logic [7:0] s1,
                                        input logic cmp);
    logic [2:0]  bp;
    logic [22:0] size;
    logic [22:0] off;
    logic        hit;
    bp   = s1[`SR1_BP_LSB +: 3];
    size = 23'h0;
    off  = {2'b00, a[20:0]};
    if (bp != 3'h0) begin
      if (s1[`SR1_SEC_BIT]) begin
        size = `SECTOR_BYTES << ((bp > 3'h4) ? 3'h3 : 3'(bp - 3'h1));
      end else begin
        size = `BLOCK_BYTES << 3'(bp - 3'h1);
        if (size > `ARRAY_BYTES) begin
          size = `ARRAY_BYTES;
        end
      end
    end
    hit = s1[`SR1_TB_BIT] ? (off < size) : (off >= 23'(`ARRAY_BYTES - size));
    return hit ^ cmp;
  endfunction

  // ---------------------------------------------------------------- link side
  logic         in_frame;
  frame_t       frm, next_frm;
  logic [7:0]   shreg, next_shreg;
  logic         prog_open, next_prog_open;
  logic [7:0]   page_ptr, next_page_ptr;
  logic [255:0] page_valid, next_page_valid;
  logic [7:0]   page_buf [256];
  logic         buf_we;
  logic         byte_done;
  frame_t       base;
  logic [3:0]   next_io_out, next_io_oe;
  logic [7:0]   rd_byte;
  logic         rd_now;
  status_t      shadow;

  // cleared by deselect, so the first edge of each frame sees a fresh start
  always_ff @(posedge serial_clk or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      in_frame <= 1'b0;
    end else begin
      in_frame <= 1'b1;
    end
  end

  // frame assembly; results stay put after deselect for the core to pick up
  always_comb begin
    base            = in_frame ? frm : '0;
    next_frm        = base;
    next_prog_open  = in_frame ? prog_open : 1'b0;
    next_page_ptr   = page_ptr;
    next_page_valid = page_valid;
    buf_we          = 1'b0;
    if (base.quad) begin
      next_shreg = {(in_frame ? shreg[3:0] : 4'h0), io_in};
    end else begin
      next_shreg = {(in_frame ? shreg[6:0] : 7'h00), io_in[0]};
    end
    next_frm.bitpos = base.bitpos + (base.quad ? 3'h4 : 3'h1);
    byte_done       = (next_frm.bitpos == 3'h0);
    if (byte_done) begin
      if (base.nbytes != 10'h3FF) begin
        next_frm.nbytes = base.nbytes + 10'h001;
      end
      case (base.nbytes)
        10'h000: begin
          next_frm.op   = next_shreg;
          // address and data of a quad program use all four lines
          next_frm.quad = (next_shreg == `OP_QUAD_PAGE_PROGRAM) &&
                          shadow.two[`SR2_QE_BIT];
          // a program frame sent while busy must not spoil the buffer in use
          next_prog_open = ((next_shreg == `OP_PAGE_PROGRAM) ||
                            (next_shreg == `OP_QUAD_PAGE_PROGRAM)) &&
                           !shadow.one[`SR1_BUSY_BIT];
          if (next_prog_open) begin
            next_page_valid = '0;
          end
        end
        10'h001, 10'h002, 10'h003: begin
          next_frm.addr = {base.addr[15:0], next_shreg};
          next_page_ptr = next_shreg;
        end
        default: begin
          if (prog_open) begin
            buf_we                    = 1'b1;
            next_page_valid[page_ptr] = 1'b1;
            next_page_ptr             = page_ptr + 8'h01;
          end
        end
      endcase
    end
  end

  always_ff @(posedge serial_clk) begin
    frm        <= next_frm;
    shreg      <= next_shreg;
    prog_open  <= next_prog_open;
    page_ptr   <= next_page_ptr;
    page_valid <= next_page_valid;
  end

  // page buffer; later bytes at the same offset overwrite earlier ones
  always_ff @(posedge serial_clk) begin
    if (buf_we) begin
      page_buf[page_ptr] <= next_shreg;
    end
  end

  // status read answers from the frozen shadow, even while busy
  always_comb begin
    case (frm.op)
      `OP_STATUS_READ_TWO:   rd_byte = shadow.two;
      `OP_STATUS_READ_THREE: rd_byte = shadow.three;
      default:               rd_byte = shadow.one;
    endcase
    rd_now = in_frame && (frm.nbytes != 10'h000) &&
             ((frm.op == `OP_STATUS_READ_ONE) || (frm.op == `OP_STATUS_READ_TWO) ||
              (frm.op == `OP_STATUS_READ_THREE));
    next_io_oe  = rd_now ? 4'b0010 : 4'b0000;
    next_io_out = {2'b00, rd_now & rd_byte[3'h7 - frm.bitpos], 1'b0};
  end

  // drive on the falling edge, release the line at once on deselect
  always_ff @(negedge serial_clk or posedge chip_sel_n) begin
    if (chip_sel_n) begin
      io_oe  <= 4'b0000;
      io_out <= 4'b0000;
    end else begin
      io_oe  <= next_io_oe;
      io_out <= next_io_out;
    end
  end

  // ---------------------------------------------------------------- core side
  logic        cs_meta, cs_sync, cs_prev;
  logic        cs_rise;
  core_state_t state, next_state;
  logic [7:0]  sr1, next_sr1;
  logic [7:0]  sr2, next_sr2;
  logic [7:0]  sr3, next_sr3;
  logic        write_latch_flag, next_wel;
  logic        vol_armed, next_vol_armed;
  logic [31:0] timer, next_timer;
  logic [8:0]  idx, next_idx;
  logic [31:0] prog_cycles;
  logic [15:0] page_base, next_page_base;
  mem_cmd_t    next_mem_cmd;
  status_t     live;
  logic        whole;
  logic        protect;
  logic        wr_ok;
  logic        vol_path;
  logic [7:0]  m2;

  // deselect pin crosses into the core clock before anything reads it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= chip_sel_n;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  assign cs_rise     = cs_sync & ~cs_prev;
  assign prog_cycles = PAGE_PROGRAM_CYCLES;
  assign live        = '{one:   {sr1[7:2], write_latch_flag, (state != ST_IDLE)},
                         two:   sr2,
                         three: sr3};

  // command decision at deselect, then the self-timed cycle
  always_comb begin
    next_state     = state;
    next_sr1       = sr1;
    next_sr2       = sr2;
    next_sr3       = sr3;
    next_wel       = write_latch_flag;
    next_vol_armed = vol_armed;
    next_timer     = timer;
    next_idx       = idx;
    next_page_base = page_base;
    next_mem_cmd   = mem_cmd;
    next_mem_cmd.we    = 1'b0;
    next_mem_cmd.erase = 1'b0;
    // a deselect in mid byte leaves a partial bit count behind
    whole    = (frm.bitpos == 3'h0);
    protect  = is_protected(frm.addr, sr1, sr2[`SR2_CMP_BIT]);
    vol_path = !write_latch_flag && vol_armed;
    wr_ok    = write_latch_flag || vol_armed;
    m2       = vol_path ? (`SR2_WRITE_MASK & ~`SR2_VOL_KEEP_MASK)
                        : `SR2_WRITE_MASK;
    case (state)
      ST_IDLE: begin
        if (cs_rise && whole) begin
          case (frm.op)
            `OP_WRITE_ENABLE: begin
              if (frm.nbytes == 10'h001) begin
                next_wel = 1'b1;
              end
            end
            `OP_WRITE_DISABLE: begin
              if (frm.nbytes == 10'h001) begin
                next_wel = 1'b0;
              end
            end
            `OP_VOL_WRITE_ENABLE: begin
              if (frm.nbytes == 10'h001) begin
                next_vol_armed = 1'b1;
              end
            end
            `OP_STATUS_WRITE_ALL, `OP_STATUS_WRITE_TWO, `OP_STATUS_WRITE_THREE: begin
              next_vol_armed = 1'b0;
              if (wr_ok) begin
                case ({frm.op, frm.nbytes})
                  {`OP_STATUS_WRITE_ALL, 10'h002}: begin
                    next_sr1 = apply_bits(sr1, frm.addr[7:0], `SR1_WRITE_MASK);
                    next_sr2 = apply_bits(sr2, 8'h00, `SR2_SHORT_MASK & m2);
                  end
                  {`OP_STATUS_WRITE_ALL, 10'h003}: begin
                    next_sr1 = apply_bits(sr1, frm.addr[15:8], `SR1_WRITE_MASK);
                    next_sr2 = apply_bits(sr2, frm.addr[7:0], m2);
                  end
                  {`OP_STATUS_WRITE_ALL, 10'h004}: begin
                    next_sr1 = apply_bits(sr1, frm.addr[23:16], `SR1_WRITE_MASK);
                    next_sr2 = apply_bits(sr2, frm.addr[15:8], m2);
                    next_sr3 = apply_bits(sr3, frm.addr[7:0], `SR3_WRITE_MASK);
                  end
                  {`OP_STATUS_WRITE_TWO, 10'h002}: begin
                    next_sr2 = apply_bits(sr2, frm.addr[7:0], m2);
                  end
                  {`OP_STATUS_WRITE_THREE, 10'h002}: begin
                    next_sr3 = apply_bits(sr3, frm.addr[7:0], `SR3_WRITE_MASK);
                  end
                  default: begin
                    next_sr1 = sr1;  // wrong length: no bit changes, but a non-volatile 3- or 4-byte frame still starts the timed cycle
                  end
                endcase
                next_sr2 = next_sr2 | (sr2 & `SR2_LOCK_MASK);
                // volatile values take effect at once with busy low
                if (!vol_path && (next_sr1 != sr1 || next_sr2 != sr2 ||
                                  next_sr3 != sr3 || frm.nbytes inside {[10'h2:10'h4]})) begin
                  next_state = ST_TIMED;
                  next_timer = STATUS_WRITE_CYCLES - 1;
                end
              end
            end
            `OP_PAGE_PROGRAM, `OP_QUAD_PAGE_PROGRAM: begin
              if (write_latch_flag && (frm.nbytes >= 10'h005) && !protect &&
                  ((frm.op == `OP_PAGE_PROGRAM) || sr2[`SR2_QE_BIT])) begin
                next_state     = ST_STREAM;
                next_idx       = 9'h000;
                next_page_base = frm.addr[23:8];
              end
            end
            `OP_SECTOR_ERASE: begin
              if (write_latch_flag && (frm.nbytes == 10'h004) && !protect) begin
                next_state         = ST_TIMED;
                next_timer         = SECTOR_ERASE_CYCLES - 1;
                next_mem_cmd.erase = 1'b1;
                next_mem_cmd.size  = ERASE_4K;
                next_mem_cmd.addr  = {frm.addr[23:12], 12'h000};
              end
            end
            `OP_BLOCK_ERASE, `OP_HALF_BLOCK_ERASE: begin
              if (write_latch_flag && (frm.nbytes == 10'h004) && !protect) begin
                next_state         = ST_TIMED;
                next_timer         = BLOCK_ERASE_CYCLES - 1;
                next_mem_cmd.erase = 1'b1;
                if (frm.op == `OP_BLOCK_ERASE) begin
                  next_mem_cmd.size = ERASE_64K;
                  next_mem_cmd.addr = {frm.addr[23:16], 16'h0000};
                end else begin
                  next_mem_cmd.size = ERASE_32K;
                  next_mem_cmd.addr = {frm.addr[23:15], 15'h0000};
                end
              end
            end
            default: begin
              next_state = ST_IDLE;
            end
          endcase
        end
      end
      ST_STREAM: begin
        // hand each collected byte to the array, one per clock
        if (page_valid[idx[7:0]]) begin
          next_mem_cmd.we   = 1'b1;
          next_mem_cmd.addr = {page_base, idx[7:0]};
          next_mem_cmd.data = page_buf[idx[7:0]];
        end
        next_idx = idx + 9'h001;
        if (idx == 9'h0FF) begin
          next_state = ST_TIMED;
          next_timer = prog_cycles - 32'd257;
        end
      end
      ST_TIMED: begin
        if (timer == 32'h0) begin
          next_state = ST_IDLE;
          next_wel   = 1'b0;
        end else begin
          next_timer = timer - 32'h1;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state     <= ST_IDLE;
      sr1       <= `SR1_RESET;
      sr2       <= `SR2_RESET;
      sr3       <= `SR3_RESET;
      write_latch_flag       <= 1'b0;
      vol_armed <= 1'b0;
      timer     <= 32'h0;
      idx       <= 9'h000;
      page_base <= 16'h0000;
      mem_cmd   <= '0;
    end else begin
      state     <= next_state;
      sr1       <= next_sr1;
      sr2       <= next_sr2;
      sr3       <= next_sr3;
      write_latch_flag       <= next_wel;
      vol_armed <= next_vol_armed;
      timer     <= next_timer;
      idx       <= next_idx;
      page_base <= next_page_base;
      mem_cmd   <= next_mem_cmd;
    end
  end

  // shadow only moves between frames, so the link side reads a steady word
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shadow      <= '0;
      status_view <= '0;
    end else begin
      status_view <= live;
      if (cs_sync) begin
        shadow <= live;
      end
    end
  end

endmodule

//--- sim/flash_write_program_erase_asserts.sv
// concurrent checks on the ports of the program and erase sequencer
`timescale 1ns/1ps
module flash_write_program_erase_asserts
  import flash_pkg::*;
#(
  parameter int unsigned STATUS_WRITE_CYCLES = 20,
  parameter int unsigned PAGE_PROGRAM_CYCLES = 300,
  parameter int unsigned SECTOR_ERASE_CYCLES = 40,
  parameter int unsigned BLOCK_ERASE_CYCLES  = 60
) (
  input logic       core_clk,
  input logic       rst,
  input logic       serial_clk,
  input logic       chip_sel_n,
  input logic [3:0] io_in,
  input logic [3:0] io_out,
  input logic [3:0] io_oe,
  input mem_cmd_t   mem_cmd,
  input status_t    status_view
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  logic [15:0] blen;
  logic [15:0] next_blen;
  logic [1:0]  kind;
  logic [1:0]  next_kind;
  int          lim;
  // busy run length and the kind of cycle that started it; kind 0 is a status write
  always_comb begin
    next_blen = status_view.one[0] ? blen + 16'h0001 : 16'h0000;
    next_kind = kind;
    if (mem_cmd.erase) begin
      next_kind = (mem_cmd.size == ERASE_4K) ? 2'd2 : 2'd3;
    end else if (mem_cmd.we) begin
      next_kind = 2'd1;
    end else if (!status_view.one[0]) begin
      next_kind = 2'd0;
    end
    case (kind)
      2'd0:    lim = STATUS_WRITE_CYCLES + 1;
      2'd1:    lim = PAGE_PROGRAM_CYCLES;
      2'd2:    lim = SECTOR_ERASE_CYCLES + 1;
      default: lim = BLOCK_ERASE_CYCLES + 1;
    endcase
  end
  always_ff @(posedge core_clk) begin
    blen <= rst ? 16'h0000 : next_blen;
    kind <= rst ? 2'd0 : next_kind;
  end
  // one cycle of slack, the view trails the live flag
  chk_busy_length: assert property ($fell(status_view.one[0]) |->
    (blen >= lim - 1) && (blen <= lim + 1)) else $error("busy length off");
  chk_latch_clear: assert property ($fell(status_view.one[0]) |->
    !status_view.one[1]) else $error("latch kept after busy");
  chk_erase_align: assert property (mem_cmd.erase |-> (mem_cmd.addr[11:0] == 12'h000) &&
    (mem_cmd.size == ERASE_4K || mem_cmd.addr[14:12] == 3'h0) &&
    (mem_cmd.size != ERASE_64K || !mem_cmd.addr[15])) else $error("erase not aligned");
  chk_erase_busy: assert property (mem_cmd.erase |=> status_view.one[0])
    else $error("erase without busy");
  chk_erase_latch: assert property (mem_cmd.erase |-> status_view.one[1:0] == 2'b10)
    else $error("erase without latch");
  chk_write_latch: assert property (mem_cmd.we |-> status_view.one[1:0] == 2'b11)
    else $error("write without latch");
  chk_lock_sticky: assert property ((status_view.two[5:3] &
    $past(status_view.two[5:3])) == $past(status_view.two[5:3])) else $error("lock bit cleared");
  chk_fixed_bits: assert property (!status_view.two[7] && status_view.three[3:0] == 4'h0)
    else $error("read-only status bit changed");
  chk_pin_drive: assert property ((io_oe == 4'h0) || (!chip_sel_n && io_oe == 4'h2))
    else $error("pin driven out of frame");
  cover property (mem_cmd.erase && mem_cmd.size == ERASE_64K);
  cover property (mem_cmd.we);
  cover property ($fell(status_view.one[0]));
  cover property (io_oe == 4'h2);
endmodule

bind flash_write_program_erase flash_write_program_erase_asserts #(
  .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
  .PAGE_PROGRAM_CYCLES(PAGE_PROGRAM_CYCLES),
  .SECTOR_ERASE_CYCLES(SECTOR_ERASE_CYCLES),
  .BLOCK_ERASE_CYCLES(BLOCK_ERASE_CYCLES)
) flash_write_program_erase_asserts_i (.core_clk(core_clk), .rst(rst),
  .serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .mem_cmd(mem_cmd), .status_view(status_view));

//--- sim/host_model.sv
// host controller model that frames serial commands to the sequencer
`timescale 1ns/1ps
module host_model (
  output logic       serial_clk,
  output logic       chip_sel_n,
  output logic [3:0] io_in,
  input  logic [3:0] io_out,
  input  logic [3:0] io_oe
);
  // clock stands low between frames, select idles high
  initial begin
    serial_clk = 1'b0;
    chip_sel_n = 1'b0;
    io_in      = 4'h0;
    // a clean rising select clears the link outputs, which have no reset of their own
    #5 chip_sel_n = 1'b1;
  end
  // 6 ns clock; undriven data line reads as unknown so a silent device never matches
  task automatic tick(input logic [3:0] v, inout logic [7:0] rd);
    io_in = v;
    #3 serial_clk = 1'b1;
    rd = {rd[6:0], io_oe[1] ? io_out[1] : 1'bx};
    #3 serial_clk = 1'b0;
  endtask
  // n whole bytes msb first, four lines from byte qa on, then extra read-back clocks
  task automatic frame(input logic [63:0] b, input int n, input int qa, input int extra,
                       output logic [7:0] rd);
    logic [7:0] v;
    rd = 8'h00;
    chip_sel_n = 1'b0;
    #60;
    for (int i = 0; i < n; i++) begin
      v = b[63 - 8 * i -: 8];
      if (i >= qa) begin
        tick(v[7:4], rd);
        tick(v[3:0], rd);
      end else begin
        for (int k = 7; k >= 0; k--) tick({3'b000, v[k]}, rd);
      end
    end
    for (int k = 0; k < extra; k++) tick(4'h0, rd);
    #3 chip_sel_n = 1'b1;
    io_in = ~io_in; // released lines must not keep the last value
    #100;
  endtask
endmodule

//--- sim/flash_write_program_erase_bench.sv
// self-checking bench of the program and erase sequencer
`timescale 1ns/1ps
`include "flash_map.svh"
module flash_write_program_erase_bench;
  import flash_pkg::*;
  localparam logic [7:0] LATCH = 8'h02;
  localparam logic [7:0] BUSYB = 8'h01;
  localparam logic [63:0] PROG = {`OP_PAGE_PROGRAM, 24'h0001FE, 32'hA55AC300};
  localparam logic [63:0] QPROG = {`OP_QUAD_PAGE_PROGRAM, 24'h000010, 32'h96000000};
  logic       core_clk;
  logic       rst;
  wire        serial_clk;
  wire        chip_sel_n;
  wire  [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  mem_cmd_t   mem_cmd;
  mem_cmd_t   last_we;
  mem_cmd_t   first_we;
  mem_cmd_t   last_er;
  status_t    status_view;
  int         fail_count = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  logic [7:0] we_n = 8'h00;
  logic       busy_seen = 1'b0;
  logic [7:0] rd;
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // short timed cycles keep the run brief
  flash_write_program_erase #(.STATUS_WRITE_CYCLES(40), .PAGE_PROGRAM_CYCLES(300),
    .SECTOR_ERASE_CYCLES(60), .BLOCK_ERASE_CYCLES(80)) flash_write_program_erase_i (
    .core_clk(core_clk), .rst(rst), .serial_clk(serial_clk), .chip_sel_n(chip_sel_n),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .mem_cmd(mem_cmd),
    .status_view(status_view));
  host_model host_model_i (.serial_clk(serial_clk), .chip_sel_n(chip_sel_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe));
  // array-side monitor and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (mem_cmd.we === 1'b1) begin
      if (we_n == 8'h00) first_we = mem_cmd;
      we_n++;
      last_we = mem_cmd;
    end
    if (mem_cmd.erase === 1'b1) last_er = mem_cmd;
    if (status_view.one[0] === 1'b1) busy_seen = 1'b1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic [63:0] b, input int n, input int qa = 9, input int extra = 0);
    host_model_i.frame(b, n, qa, extra, rd);
  endtask
  task automatic op1(input logic [7:0] op);
    xfer({op, 56'h0}, 1);
  endtask
  task automatic poll(input logic [7:0] exp);
    xfer({`OP_STATUS_READ_ONE, 56'h0}, 1, 9, 8);
    chk_byte("status read", exp, rd);
  endtask
  // bounded wait for busy and latch to drop
  task automatic wait_idle();
    for (int k = 0; k < 500 && status_view.one[1:0] !== 2'b00; k++) @(posedge core_clk);
    chk_byte("idle flags", 8'h00, {6'h00, status_view.one[1:0]});
  endtask
  task automatic s_latch();
    op1(`OP_WRITE_ENABLE);
    poll(LATCH);
    op1(`OP_WRITE_DISABLE);
    chk_byte("status one", 8'h00, status_view.one);
  endtask
  task automatic s_status_nv();
    // reserved bits written as zero, read-only bits as one
    xfer({`OP_STATUS_WRITE_ALL, 24'hFFFBF0, 32'h0}, 4);
    chk_byte("status one", 8'h00, status_view.one);
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_STATUS_WRITE_ALL, 24'hFFFBF0, 32'h0}, 4);
    poll(`SR1_WRITE_MASK | LATCH | BUSYB);
    wait_idle();
    chk_byte("status one", `SR1_WRITE_MASK, status_view.one);
    chk_byte("status two", 8'hFB & `SR2_WRITE_MASK, status_view.two);
    chk_byte("status three", `SR3_WRITE_MASK, status_view.three);
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_STATUS_WRITE_ALL, 56'h0}, 4);
    wait_idle();
    chk_byte("status two", `SR2_LOCK_MASK, status_view.two);
    chk_byte("status three", 8'h00, status_view.three);
  endtask
  task automatic s_length();
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_STATUS_WRITE_ALL, 8'h80, 48'h0}, 2, 9, 4);
    chk_byte("status one", LATCH, status_view.one);
    xfer({`OP_STATUS_WRITE_TWO, `SR2_SHORT_MASK, 48'h0}, 2);
    wait_idle();
    chk_byte("status two", `SR2_SHORT_MASK | `SR2_LOCK_MASK, status_view.two);
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_STATUS_WRITE_ALL, 56'h0}, 2);
    wait_idle();
    chk_byte("status two", `SR2_LOCK_MASK, status_view.two);
  endtask
  task automatic s_program();
    we_n = 8'h00;
    xfer(PROG, 7);
    chk_byte("write count", 8'h00, we_n);
    op1(`OP_WRITE_ENABLE);
    xfer(PROG, 7, 9, 4);
    chk_byte("write count", 8'h00, we_n);
    xfer(PROG, 7);
    poll(LATCH | BUSYB);
    wait_idle();
    chk_byte("write count", 8'h03, we_n);
    // the array sees the page in offset order, so the wrapped byte comes first
    chk_word("first write", {24'h000100, 8'hC3}, {first_we.addr, first_we.data});
    chk_word("last write", {24'h0001FF, 8'h5A}, {last_we.addr, last_we.data});
  endtask
  task automatic s_volatile();
    op1(`OP_VOL_WRITE_ENABLE);
    busy_seen = 1'b0;
    xfer({`OP_STATUS_WRITE_TWO, 8'h03, 48'h0}, 2);
    chk_byte("status two", (8'h03 & `SR2_WRITE_MASK & ~`SR2_VOL_KEEP_MASK) |
      `SR2_LOCK_MASK, status_view.two);
    chk_byte("status one", 8'h00, status_view.one);
    chk_byte("busy seen", 8'h00, {7'h00, busy_seen});
  endtask
  task automatic s_quad();
    we_n = 8'h00;
    op1(`OP_WRITE_ENABLE);
    xfer(QPROG, 5, 1);
    wait_idle();
    chk_byte("write count", 8'h01, we_n);
    chk_word("quad write", {24'h000010, 8'h96}, {last_we.addr, last_we.data});
    op1(`OP_VOL_WRITE_ENABLE);
    xfer({`OP_STATUS_WRITE_TWO, 56'h0}, 2);
    op1(`OP_WRITE_ENABLE);
    // single-line frame: whole on the link, so only the quad-enable gate can refuse it
    xfer(QPROG, 5);
    chk_byte("write count", 8'h01, we_n);
    op1(`OP_WRITE_DISABLE);
  endtask
  task automatic s_erase();
    logic [7:0]  ops[3];
    logic [23:0] szs[3];
    ops = '{`OP_SECTOR_ERASE, `OP_HALF_BLOCK_ERASE, `OP_BLOCK_ERASE};
    szs = '{{1'b0, `SECTOR_BYTES}, {1'b0, `HALF_BLOCK_BYTES}, {1'b0, `BLOCK_BYTES}};
    for (int i = 0; i < 3; i++) begin
      last_er = '0;
      op1(`OP_WRITE_ENABLE);
      xfer({ops[i], 24'h012345, 32'h0}, 4);
      wait_idle();
      chk_word("erase cmd", {6'h00, 2'(i), 24'h012345 & ~(szs[i] - 24'h1)},
        {6'h00, last_er.size, last_er.addr});
    end
    last_er = '0;
    xfer({`OP_SECTOR_ERASE, 24'h012345, 32'h0}, 4);
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_SECTOR_ERASE, 24'h012345, 32'h0}, 4, 9, 4);
    xfer({`OP_BLOCK_ERASE, 24'h012345, 32'h0}, 3);
    xfer({`OP_STATUS_WRITE_ALL, 8'h04, 48'h0}, 2);
    wait_idle();
    op1(`OP_WRITE_ENABLE);
    xfer({`OP_SECTOR_ERASE, 24'h1F0000, 32'h0}, 4);
    chk_word("refused erase", 32'h0, {6'h00, last_er.size, last_er.addr});
    xfer({`OP_STATUS_WRITE_ALL, 56'h0}, 2);
    wait_idle();
  endtask
  initial begin
    rst = 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk_byte("reset status", 8'h00, status_view.one | status_view.two | status_view.three);
    s_latch();
    s_status_nv();
    s_length();
    s_program();
    s_volatile();
    s_quad();
    s_erase();
    complete_run();
  end
endmodule
